// >>> verilog/pit_pkg.sv
// Constants and types shared by both ends of the bus link
// How it works
// - Address and command in first FRAME clock
// - Data phases carry byte enables on C/BE
// - Read: initiator releases AD, turnaround before data
// - Target drives AD only after DEVSEL asserted
// - Target AD drivers stay on until end
// - Word moves only when IRDY and TRDY low
// - Last phase: IRDY low, FRAME high
// - Write data directly after address, no turnaround
// - CPU initiator write wait: hold data, drop enables; DMA keeps them
// - DMA bursts keep IRDY asserted, zero waits, while the buffer holds data (write) or room (read)
// - Fast back-to-back: later transactions wait once
// - Target waits by holding TRDY high
// - Target waits: cfg rd 2, rd 3, wr 0
// - Initiator for DMA, target for host accesses
// - Split address and direction sampled on clock
// - Split mode: PAR driven constantly low
package pit_pkg;
  localparam logic [3:0] CMD_MEM_RD  = 4'h6;
  localparam logic [3:0] CMD_MEM_WR  = 4'h7;
  localparam logic [3:0] CMD_CFG_RD  = 4'ha;
  localparam logic [3:0] CMD_CFG_WR  = 4'hb;
  localparam logic [3:0] BE_ALL      = 4'h0;
  localparam logic [3:0] BE_NONE     = 4'hf;
  localparam logic [1:0] WAIT_CFG_RD = 2'h2;
  localparam logic [1:0] WAIT_REG_RD = 2'h3;
  localparam logic [1:0] WAIT_LP_RD  = 2'h3;
  localparam logic [1:0] WAIT_WR     = 2'h0;
  localparam logic [1:0] WAIT_FB2    = 2'h1;
  localparam logic [1:0] WAIT_BURST  = 2'h0;
  localparam int         LP_SEL_BIT  = 16;
  localparam logic [4:0] TGT_LIMIT   = 5'h10;
  localparam logic [2:0] ABORT_LIMIT = 3'h5;
  localparam logic [31:0] ADDR_STEP  = 32'h4;
  typedef enum logic [1:0] {SP_CFG, SP_REG, SP_LP} pit_space_t;
  typedef enum logic [1:0] {I_IDLE, I_ADDR, I_DATA} pit_ist_t;
  typedef enum logic {T_IDLE, T_DATA} pit_tst_t;
endpackage

// >>> verilog/pit_bus_if.sv
// Shared bus wires: per-end drivers and resolved levels
`timescale 1ns/1ps
interface pit_bus_if;
  logic        dFrameB, dIrdyB, dMstOeB, dTrdyB, dDevselB, dTgtOeB, dAdOeB, dPar, dParOeB, dDmWr, reqB;
  logic        hFrameB, hIrdyB, hMstOeB, hTrdyB, hDevselB, hTgtOeB, hAdOeB, hPar, hParOeB, hDmWr, gntB;
  logic [3:0]  dCbeB, hCbeB;
  logic [31:0] dAd, hAd, dDmAddr, hDmAddr;
  logic        frameB, irdyB, trdyB, devselB, par, dmWr;
  logic [3:0]  cbeB;
  logic [31:0] ad, dmAddr;
  // Undriven lines float high, as with the pull-ups
  assign frameB  = !dMstOeB ? dFrameB  : !hMstOeB ? hFrameB  : 1'b1;
  assign irdyB   = !dMstOeB ? dIrdyB   : !hMstOeB ? hIrdyB   : 1'b1;
  assign cbeB    = !dMstOeB ? dCbeB    : !hMstOeB ? hCbeB    : 4'hf;
  assign dmAddr  = !dMstOeB ? dDmAddr  : !hMstOeB ? hDmAddr  : 32'hffff_ffff;
  assign dmWr    = !dMstOeB ? dDmWr    : !hMstOeB ? hDmWr    : 1'b1;
  assign trdyB   = !dTgtOeB ? dTrdyB   : !hTgtOeB ? hTrdyB   : 1'b1;
  assign devselB = !dTgtOeB ? dDevselB : !hTgtOeB ? hDevselB : 1'b1;
  assign ad      = !dAdOeB  ? dAd      : !hAdOeB  ? hAd      : 32'hffff_ffff;
  assign par     = !dParOeB ? dPar     : !hParOeB ? hPar     : 1'b1;
  modport dev (output dFrameB, dIrdyB, dMstOeB, dCbeB, dDmAddr, dDmWr, dTrdyB, dDevselB, dTgtOeB,
               output dAd, dAdOeB, dPar, dParOeB, reqB,
               input  frameB, irdyB, trdyB, devselB, cbeB, ad, par, dmAddr, dmWr, gntB);
  modport host (output hFrameB, hIrdyB, hMstOeB, hCbeB, hDmAddr, hDmWr, hTrdyB, hDevselB, hTgtOeB,
                output hAd, hAdOeB, hPar, hParOeB, gntB,
                input  frameB, irdyB, trdyB, devselB, cbeB, ad, par, dmAddr, dmWr, reqB);
endinterface

// >>> verilog/pit_dev_end.sv
// Device end: DMA burst initiator, register and port target, word buffer
`timescale 1ns/1ps
module pit_fifo #(
  parameter int W     = 36,
  parameter int DEPTH = 2
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0] memQ [DEPTH];
  logic [AW-1:0] wrQ, rdQ;
  logic [AW:0]   cntQ;
  logic          push, pop;

  if (DEPTH < 1 || W < 1) begin : g_bad
    $error("pit_fifo: DEPTH and W must be at least 1");
  end

  assign inReady  = cntQ != (AW+1)'(DEPTH);
  assign outValid = cntQ != '0;
  assign outData  = memQ[rdQ];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
    begin
      for (int i = 0; i < DEPTH; i++)
        memQ[i] <= '0;
      wrQ <= '0;
    end
    else if (push)
    begin
      memQ[wrQ] <= inData;
      wrQ       <= (wrQ == AW'(DEPTH-1)) ? '0 : wrQ + 1'b1;
    end

  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      rdQ <= '0;
    else if (pop)
      rdQ <= (rdQ == AW'(DEPTH-1)) ? '0 : rdQ + 1'b1;

  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      cntQ <= '0;
    else if (push != pop)
      cntQ <= push ? cntQ + 1'b1 : cntQ - 1'b1;
endmodule // pit_fifo

module pit_dev_end #(
  parameter int          WIN_BITS  = 17,
  parameter logic [31:0] WIN_BASE  = 32'h0002_0000,
  parameter int          BUF_DEPTH = 2
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  pit_bus_if.dev                 bus,
  input  wire logic              demuxMode,
  input  wire logic              dmaReqValid,
  output logic                   dmaReqReady,
  input  wire logic              dmaWrite,
  input  wire logic [31:0]       dmaAddr,
  input  wire logic [7:0]        dmaLen,
  input  wire logic              dmaFastB2b,
  output logic                   dmaBusy,
  input  wire logic              wrValid,
  output logic                   wrReady,
  input  wire logic [31:0]       wrData,
  input  wire logic [3:0]        wrBeB,
  output logic                   rdValid,
  input  wire logic              rdReady,
  output logic [31:0]            rdData,
  output logic                   tgtStrobe,
  output logic                   tgtWrite,
  output pit_pkg::pit_space_t    tgtSpace,
  output logic [31:0]            tgtAddr,
  output logic [31:0]            tgtWrData,
  output logic [3:0]             tgtBeB,
  input  wire logic [31:0]       tgtRdData
);
  if (WIN_BITS <= pit_pkg::LP_SEL_BIT || WIN_BITS > 31) begin : g_bad
    $error("pit_dev_end: WIN_BITS must lie above the port select bit and below 32");
  end

  pit_pkg::pit_ist_t   iStQ;
  pit_pkg::pit_tst_t   tStQ;
  pit_pkg::pit_space_t tSpaceQ, spaceIn;
  logic [31:0] iAddrQ, tAddrQ, tRdQ, adOut, addrIn;
  logic [7:0]  iCntQ;
  logic [1:0]  iWaitQ, tWaitQ, waitIn;
  logic [4:0]  tAgeQ;
  logic        iWrQ, tWrQ, tAdOnQ, frameQ, parQ, parOnQ;
  logic        wfValid, wfPop, rfReady, irdyAct, lastPh, iXfer, busIdle, startNew, startFb;
  logic        iAdOn, adOeB, addrPh, isCfg, isMem, hit, wrIn, trdyAct, tXfer, tEnd;
  logic [35:0] wfData;

  ////////////////////////////////////////////////////////////////////////////
  // Buffers: a stalled target or reader holds words, never drops them
  pit_fifo #(.W(36), .DEPTH(BUF_DEPTH)) u_wrBuf (
    .clk_sys (clk_sys), .rst_b (rst_b),
    .inValid (wrValid), .inReady (wrReady), .inData ({wrBeB, wrData}),
    .outValid (wfValid), .outReady (wfPop), .outData (wfData));
  pit_fifo #(.W(32), .DEPTH(BUF_DEPTH)) u_rdBuf (
    .clk_sys (clk_sys), .rst_b (rst_b),
    .inValid (iXfer && !iWrQ), .inReady (rfReady), .inData (bus.ad),
    .outValid (rdValid), .outReady (rdReady), .outData (rdData));

  ////////////////////////////////////////////////////////////////////////////
  // Initiator
  // IRDY held low while write data or read room is on hand and no start wait is left
  assign irdyAct     = iStQ == pit_pkg::I_DATA && iWaitQ == '0 && (iWrQ ? wfValid : rfReady);
  assign lastPh      = iCntQ <= 8'd1;
  // Word moves on IRDY and TRDY
  assign iXfer       = irdyAct && !bus.trdyB;
  assign wfPop       = iXfer && iWrQ;
  assign busIdle     = bus.frameB && bus.irdyB;
  assign startNew    = iStQ == pit_pkg::I_IDLE && dmaReqValid && !bus.gntB && busIdle && tStQ == pit_pkg::T_IDLE;
  assign startFb     = iXfer && lastPh && dmaReqValid && dmaFastB2b && !bus.gntB;
  assign dmaReqReady = startNew || startFb;
  assign dmaBusy     = iStQ != pit_pkg::I_IDLE;

  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      iStQ <= pit_pkg::I_IDLE;
    else
      case (iStQ)
        pit_pkg::I_IDLE: if (startNew) iStQ <= pit_pkg::I_ADDR;
        pit_pkg::I_ADDR: iStQ <= pit_pkg::I_DATA;
        pit_pkg::I_DATA: if (iXfer && lastPh) iStQ <= startFb ? pit_pkg::I_ADDR : pit_pkg::I_IDLE;
        default:         iStQ <= pit_pkg::I_IDLE;
      endcase

  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
    begin
      iAddrQ <= '0;
      iWrQ   <= 1'b0;
      iCntQ  <= '0;
      iWaitQ <= '0;
    end
    else if (dmaReqReady)
    begin
      iAddrQ <= dmaAddr;
      iWrQ   <= dmaWrite;
      iCntQ  <= dmaLen;
      // One wait only after a back-to-back start
      iWaitQ <= startFb ? pit_pkg::WAIT_FB2 : pit_pkg::WAIT_BURST;
    end
    else if (iXfer)
    begin
      iAddrQ <= iAddrQ + pit_pkg::ADDR_STEP;
      iCntQ  <= iCntQ - 8'd1;
    end
    else if (iStQ == pit_pkg::I_DATA && iWaitQ != '0)
      iWaitQ <= iWaitQ - 2'd1;

  assign bus.reqB    = !(dmaReqValid || iStQ != pit_pkg::I_IDLE);
  assign bus.dMstOeB = iStQ == pit_pkg::I_IDLE;
  // FRAME rises only with IRDY low on last phase
  assign bus.dFrameB = !(iStQ == pit_pkg::I_ADDR || (iStQ == pit_pkg::I_DATA && !(lastPh && irdyAct)));
  assign bus.dIrdyB  = !irdyAct;
  // Command in address clock, enables after
  assign bus.dCbeB   = iStQ == pit_pkg::I_ADDR ? (iWrQ ? pit_pkg::CMD_MEM_WR : pit_pkg::CMD_MEM_RD)
                     : iWrQ ? wfData[35:32] : pit_pkg::BE_ALL;
  // Split address and direction with the master lines
  assign bus.dDmAddr = iAddrQ;
  assign bus.dDmWr   = iWrQ;

  // Write data follows address; reads release AD
  assign iAdOn  = iStQ == pit_pkg::I_ADDR || (iStQ == pit_pkg::I_DATA && iWrQ);
  assign adOut  = iAdOn ? (iStQ == pit_pkg::I_ADDR ? iAddrQ : wfData[31:0]) : tRdQ;
  assign adOeB  = !(iAdOn || tAdOnQ);
  assign bus.dAd    = adOut;
  assign bus.dAdOeB = adOeB;

  ////////////////////////////////////////////////////////////////////////////
  // Parity trails its data by one clock
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
    begin
      parQ   <= 1'b0;
      parOnQ <= 1'b0;
    end
    else
    begin
      parQ   <= ^{adOut, bus.cbeB};
      parOnQ <= !adOeB;
    end

  // Split mode: PAR held low, no parity
  assign bus.dPar    = demuxMode ? 1'b0 : parQ;
  assign bus.dParOeB = demuxMode ? 1'b0 : !parOnQ;

  ////////////////////////////////////////////////////////////////////////////
  // Target
  // Split mode samples address and direction lines
  assign addrIn  = demuxMode ? bus.dmAddr : bus.ad;
  assign wrIn    = demuxMode ? bus.dmWr : bus.cbeB[0];
  assign isCfg   = bus.cbeB == pit_pkg::CMD_CFG_RD || bus.cbeB == pit_pkg::CMD_CFG_WR;
  assign isMem   = bus.cbeB == pit_pkg::CMD_MEM_RD || bus.cbeB == pit_pkg::CMD_MEM_WR;
  // Address taken in first FRAME clock
  assign addrPh  = !bus.frameB && frameQ && iStQ == pit_pkg::I_IDLE && tStQ == pit_pkg::T_IDLE;
  // Claims configuration, registers and local port
  assign hit     = isCfg || (isMem && addrIn[31:WIN_BITS] == WIN_BASE[31:WIN_BITS]);
  assign spaceIn = isCfg ? pit_pkg::SP_CFG : addrIn[pit_pkg::LP_SEL_BIT] ? pit_pkg::SP_LP : pit_pkg::SP_REG;

  // Wait counts per space and direction
  function automatic logic [1:0] waitFor(input pit_pkg::pit_space_t sp, input logic wr);
    if (wr)
      return pit_pkg::WAIT_WR;
    case (sp)
      pit_pkg::SP_CFG: return pit_pkg::WAIT_CFG_RD;
      pit_pkg::SP_LP:  return pit_pkg::WAIT_LP_RD;
      default:         return pit_pkg::WAIT_REG_RD;
    endcase
  endfunction

  assign waitIn  = waitFor(spaceIn, wrIn);
  // TRDY high until the wait count runs out
  assign trdyAct = tStQ == pit_pkg::T_DATA && tWaitQ == '0;
  assign tXfer   = trdyAct && !bus.irdyB;
  // Stuck access dropped after a bounded count
  assign tEnd    = (tXfer && bus.frameB) || tAgeQ == pit_pkg::TGT_LIMIT;

  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      frameQ <= 1'b1;
    else
      frameQ <= bus.frameB;

  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      tStQ <= pit_pkg::T_IDLE;
    else
      case (tStQ)
        pit_pkg::T_IDLE: if (addrPh && hit) tStQ <= pit_pkg::T_DATA;
        pit_pkg::T_DATA: if (tEnd) tStQ <= pit_pkg::T_IDLE;
        default:         tStQ <= pit_pkg::T_IDLE;
      endcase

  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
    begin
      tAddrQ  <= '0;
      tWrQ    <= 1'b0;
      tSpaceQ <= pit_pkg::SP_CFG;
      tWaitQ  <= '0;
      tAgeQ   <= '0;
    end
    else if (addrPh && hit)
    begin
      tAddrQ  <= addrIn;
      tWrQ    <= wrIn;
      tSpaceQ <= spaceIn;
      tWaitQ  <= waitIn;
      tAgeQ   <= '0;
    end
    else if (tXfer)
    begin
      tAddrQ <= tAddrQ + pit_pkg::ADDR_STEP;
      tWaitQ <= waitFor(tSpaceQ, tWrQ);
      tAgeQ  <= '0;
    end
    else if (tStQ == pit_pkg::T_DATA)
    begin
      if (tWaitQ != '0)
        tWaitQ <= tWaitQ - 2'd1;
      tAgeQ <= tAgeQ + 5'd1;
    end

  // AD on from the clock after DEVSEL; held to the end
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      tAdOnQ <= 1'b0;
    else
      tAdOnQ <= tStQ == pit_pkg::T_DATA && !tWrQ && !tEnd;

  // Read word is taken in the last wait clock, so reads need one wait
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      tRdQ <= '0;
    else if (tStQ == pit_pkg::T_DATA && tWaitQ == 2'd1)
      tRdQ <= tgtRdData;

  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
    begin
      tgtStrobe <= 1'b0;
      tgtWrite  <= 1'b0;
      tgtSpace  <= pit_pkg::SP_CFG;
      tgtAddr   <= '0;
      tgtWrData <= '0;
      tgtBeB    <= pit_pkg::BE_NONE;
    end
    else
    begin
      tgtStrobe <= (addrPh && hit) || (tXfer && (tWrQ || !bus.frameB));
      tgtWrite  <= tStQ == pit_pkg::T_DATA ? tWrQ && tXfer : wrIn;
      tgtSpace  <= tStQ == pit_pkg::T_DATA ? tSpaceQ : spaceIn;
      tgtAddr   <= tStQ == pit_pkg::T_IDLE ? addrIn : tWrQ ? tAddrQ : tAddrQ + pit_pkg::ADDR_STEP;
      tgtWrData <= bus.ad;
      tgtBeB    <= bus.cbeB;
    end

  assign bus.dTgtOeB  = tStQ == pit_pkg::T_IDLE;
  assign bus.dDevselB = 1'b0;
  assign bus.dTrdyB   = !trdyAct;
endmodule // pit_dev_end

// >>> verilog/pit_host_end.sv
// Host end: CPU single-word initiator and memory target for DMA
`timescale 1ns/1ps
module pit_host_end #(
  parameter logic [1:0] MEM_WAIT = 2'h0
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  pit_bus_if.host          bus,
  input  wire logic        demuxMode,
  input  wire logic        cpuValid,
  output logic             cpuReady,
  input  wire logic        cpuWrite,
  input  wire logic        cpuCfg,
  input  wire logic [31:0] cpuAddr,
  input  wire logic [31:0] cpuData,
  input  wire logic [3:0]  cpuBeB,
  input  wire logic        cpuStall,
  output logic             cpuDone,
  output logic             cpuAbort,
  output logic [31:0]      cpuRdData,
  output logic             memWrStrobe,
  output logic [31:0]      memAddr,
  output logic [31:0]      memWrData,
  output logic [3:0]       memBeB,
  input  wire logic [31:0] memRdData
);
  pit_pkg::pit_ist_t hStQ;
  pit_pkg::pit_tst_t tStQ;
  logic [31:0] hAddrQ, hDataQ, tAddrQ, tRdQ, adOut, addrIn;
  logic [3:0]  hBeQ, hCmdQ;
  logic [2:0]  ageQ;
  logic [1:0]  tWaitQ;
  logic        hWrQ, irdyOnQ, gntQ, frameQ, tWrQ, tAdOnQ, parQ, parOnQ;
  logic        busIdle, irdyAct, hXfer, hAbort, addrPh, trdyAct, tXfer, adOeB, wrIn;

  ////////////////////////////////////////////////////////////////////////////
  // Grant the device only while the CPU side is quiet
  assign busIdle = bus.frameB && bus.irdyB;
  assign cpuReady = hStQ == pit_pkg::I_IDLE && cpuValid && !gntQ && busIdle && tStQ == pit_pkg::T_IDLE;

  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      gntQ <= 1'b0;
    else
      gntQ <= !bus.reqB && (gntQ || (hStQ == pit_pkg::I_IDLE && !cpuValid && busIdle));

  assign bus.gntB = !gntQ;

  ////////////////////////////////////////////////////////////////////////////
  // Initiator, one data phase per request
  // Stall withdraws enables until IRDY first asserted
  assign irdyAct = hStQ == pit_pkg::I_DATA && !(cpuStall && !irdyOnQ);
  // Word moves on IRDY and TRDY
  assign hXfer   = irdyAct && !bus.trdyB;
  assign hAbort  = hStQ == pit_pkg::I_DATA && ageQ == pit_pkg::ABORT_LIMIT && bus.devselB;

  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      hStQ <= pit_pkg::I_IDLE;
    else
      case (hStQ)
        pit_pkg::I_IDLE: if (cpuReady) hStQ <= pit_pkg::I_ADDR;
        pit_pkg::I_ADDR: hStQ <= pit_pkg::I_DATA;
        pit_pkg::I_DATA: if (hXfer || hAbort) hStQ <= pit_pkg::I_IDLE;
        default:         hStQ <= pit_pkg::I_IDLE;
      endcase

  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
    begin
      hAddrQ  <= '0;
      hDataQ  <= '0;
      hBeQ    <= pit_pkg::BE_NONE;
      hCmdQ   <= pit_pkg::CMD_MEM_RD;
      hWrQ    <= 1'b0;
      irdyOnQ <= 1'b0;
      ageQ    <= '0;
    end
    else if (cpuReady)
    begin
      hAddrQ  <= cpuAddr;
      hDataQ  <= cpuData;
      hBeQ    <= cpuBeB;
      hWrQ    <= cpuWrite;
      hCmdQ   <= cpuCfg ? (cpuWrite ? pit_pkg::CMD_CFG_WR : pit_pkg::CMD_CFG_RD)
                        : (cpuWrite ? pit_pkg::CMD_MEM_WR : pit_pkg::CMD_MEM_RD);
      irdyOnQ <= 1'b0;
      ageQ    <= '0;
    end
    else if (hStQ == pit_pkg::I_DATA)
    begin
      irdyOnQ <= irdyOnQ || irdyAct;
      if (ageQ != pit_pkg::ABORT_LIMIT)
        ageQ <= ageQ + 3'd1;
    end

  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
    begin
      cpuDone   <= 1'b0;
      cpuAbort  <= 1'b0;
      cpuRdData <= '0;
    end
    else
    begin
      cpuDone  <= hXfer || hAbort;
      cpuAbort <= hAbort && !hXfer;
      if (hXfer && !hWrQ)
        cpuRdData <= bus.ad;
      else if (hAbort)
        cpuRdData <= 32'hffff_ffff;
    end

  assign bus.hMstOeB = hStQ == pit_pkg::I_IDLE;
  // FRAME rises only together with IRDY
  assign bus.hFrameB = !(hStQ == pit_pkg::I_ADDR || (hStQ == pit_pkg::I_DATA && !irdyAct));
  assign bus.hIrdyB  = !irdyAct;
  // Command in address clock; enables, withdrawn in waits
  assign bus.hCbeB   = hStQ == pit_pkg::I_ADDR ? hCmdQ : irdyAct ? hBeQ : pit_pkg::BE_NONE;
  assign bus.hDmAddr = hAddrQ;
  assign bus.hDmWr   = hWrQ;

  ////////////////////////////////////////////////////////////////////////////
  // Memory target, claims memory cycles while the device holds grant
  assign addrIn  = demuxMode ? bus.dmAddr : bus.ad;
  assign wrIn    = demuxMode ? bus.dmWr : bus.cbeB[0];
  assign addrPh  = !bus.frameB && frameQ && gntQ && tStQ == pit_pkg::T_IDLE
                && (bus.cbeB == pit_pkg::CMD_MEM_RD || bus.cbeB == pit_pkg::CMD_MEM_WR);
  // Read data only after the turnaround clock
  assign trdyAct = tStQ == pit_pkg::T_DATA && tWaitQ == '0 && (tWrQ || tAdOnQ);
  assign tXfer   = trdyAct && !bus.irdyB;
  assign memAddr = memWrStrobe ? tAddrQ - pit_pkg::ADDR_STEP : tXfer ? tAddrQ + pit_pkg::ADDR_STEP : tAddrQ;

  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      frameQ <= 1'b1;
    else
      frameQ <= bus.frameB;

  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
    begin
      tStQ   <= pit_pkg::T_IDLE;
      tAddrQ <= '0;
      tWrQ   <= 1'b0;
      tWaitQ <= '0;
      tAdOnQ <= 1'b0;
    end
    else if (addrPh)
    begin
      tStQ   <= pit_pkg::T_DATA;
      tAddrQ <= addrIn;
      tWrQ   <= wrIn;
      tWaitQ <= MEM_WAIT;
    end
    else if (tStQ == pit_pkg::T_DATA)
    begin
      // AD kept on until the last word
      tAdOnQ <= !tWrQ && !(tXfer && bus.frameB);
      if (tXfer && bus.frameB)
        tStQ <= pit_pkg::T_IDLE;
      if (tXfer)
      begin
        tAddrQ <= tAddrQ + pit_pkg::ADDR_STEP;
        tWaitQ <= MEM_WAIT;
      end
      else if (tWaitQ != '0)
        tWaitQ <= tWaitQ - 2'd1;
    end

  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
    begin
      tRdQ        <= '0;
      memWrStrobe <= 1'b0;
      memWrData   <= '0;
      memBeB      <= pit_pkg::BE_NONE;
    end
    else
    begin
      tRdQ        <= memRdData;
      memWrStrobe <= tXfer && tWrQ;
      memWrData   <= bus.ad;
      memBeB      <= bus.cbeB;
    end

  assign bus.hTgtOeB  = tStQ == pit_pkg::T_IDLE;
  assign bus.hDevselB = 1'b0;
  assign bus.hTrdyB   = !trdyAct;

  ////////////////////////////////////////////////////////////////////////////
  // AD and parity; in split mode the device owns PAR
  assign adOut      = (hStQ == pit_pkg::I_ADDR) ? hAddrQ : (hStQ == pit_pkg::I_DATA && hWrQ) ? hDataQ : tRdQ;
  assign adOeB      = !(hStQ == pit_pkg::I_ADDR || (hStQ == pit_pkg::I_DATA && hWrQ) || tAdOnQ);
  assign bus.hAd    = adOut;
  assign bus.hAdOeB = adOeB;

  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
    begin
      parQ   <= 1'b0;
      parOnQ <= 1'b0;
    end
    else
    begin
      parQ   <= ^{adOut, bus.cbeB};
      parOnQ <= !adOeB && !demuxMode;
    end

  assign bus.hPar    = parQ;
  assign bus.hParOeB = !parOnQ;
endmodule // pit_host_end

// >>> dv/pit_bus_properties.sv
// Bus-level property checker for the link between the two ends
`timescale 1ns/1ps
module pit_bus_properties #(
  parameter logic [31:0] WIN_BASE = 32'h0002_0000
) (
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic        frameB,
  input wire logic        irdyB,
  input wire logic        trdyB,
  input wire logic        devselB,
  input wire logic [3:0]  cbeB,
  input wire logic [31:0] ad,
  input wire logic        dMstOeB,
  input wire logic        dAdOeB,
  input wire logic        dTgtOeB
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // Host-started cycle that lands in the device window
  wire hostHit = dMstOeB && ad[31:17] == WIN_BASE[31:17];
  wire lastMove = frameB && !irdyB && !trdyB;
  ////////////////////////////////////////////////////////////////////////////////
  a_trdy_needs_sel: assert property (!dTgtOeB && !trdyB |-> !devselB)
    else $error("target ready without select");
  a_ad_needs_sel: assert property (dMstOeB && !dAdOeB |-> !dTgtOeB && !devselB)
    else $error("target data without select");
  a_ad_held_on: assert property (dMstOeB && !dAdOeB && !lastMove |=> !dAdOeB)
    else $error("target data dropped early");
  a_frame_with_irdy: assert property (!dMstOeB && $rose(frameB) |-> !irdyB)
    else $error("frame ended without initiator ready");
  a_burst_no_wait: assert property (!dMstOeB && !frameB && !irdyB && !trdyB |=> !irdyB)
    else $error("initiator wait inside burst");
  a_wr_no_turn: assert property (!dMstOeB && $fell(frameB) && cbeB == pit_pkg::CMD_MEM_WR |=> !dAdOeB)
    else $error("write data late");
  a_rd_turnaround: assert property (!dMstOeB && $fell(frameB) && cbeB == pit_pkg::CMD_MEM_RD |=> dAdOeB)
    else $error("read address not released");
  a_cfg_rd_wait: assert property (dMstOeB && $fell(frameB) && cbeB == pit_pkg::CMD_CFG_RD
    |=> !devselB && trdyB ##1 trdyB ##1 !trdyB) else $error("config read wait count");
  a_reg_rd_wait: assert property ($fell(frameB) && hostHit && cbeB == pit_pkg::CMD_MEM_RD
    |=> trdyB[*3] ##1 !trdyB) else $error("register read wait count");
  a_wr_zero_wait: assert property (dMstOeB && $fell(frameB) && (cbeB == pit_pkg::CMD_CFG_WR
    || hostHit && cbeB == pit_pkg::CMD_MEM_WR) |=> !trdyB) else $error("target write waited");
  a_be_off: assert property (dMstOeB && !frameB && irdyB && !$fell(frameB) |-> cbeB == pit_pkg::BE_NONE)
    else $error("enables kept");
  c_cfg_read: cover property ($fell(frameB) && cbeB == pit_pkg::CMD_CFG_RD);
  c_dma_write: cover property (!dMstOeB && $fell(frameB) && cbeB == pit_pkg::CMD_MEM_WR);
  c_dma_read: cover property (!dMstOeB && $fell(frameB) && cbeB == pit_pkg::CMD_MEM_RD);
endmodule // pit_bus_properties

// >>> dv/tb_top.sv
// Self-checking bench for both ends of the bus link
`timescale 1ns/1ps
module tb_top;
  localparam logic [31:0] K = 32'hface_0000;
  logic clk_sys = 1'b0, rst_b = 1'b0, demuxMode = 1'b0, cpuStall = 1'b0;
  logic dmaReqValid = 1'b0, dmaWrite = 1'b0, dmaFastB2b = 1'b0, wrValid = 1'b0, rdReady = 1'b1;
  logic cpuValid = 1'b0, cpuWrite = 1'b0, cpuCfg = 1'b0;
  logic [31:0] dmaAddr = 32'h0, wrData = 32'h0, cpuAddr = 32'h0, cpuData = 32'h0, tgtRdData = 32'h0;
  logic [7:0] dmaLen = 8'h2;
  logic [3:0] wrBeB = 4'h0, cpuBeB = 4'h0, tgtBeB, memBeB, tSp;
  logic dmaReqReady, dmaBusy, wrReady, rdValid, tgtStrobe, tgtWrite, cpuReady, cpuDone, cpuAbort, memWrStrobe;
  logic [31:0] rdData, tgtAddr, tgtWrData, cpuRdData, memAddr, memWrData, memRdData, r, tData;
  pit_pkg::pit_space_t tgtSpace;
  logic [35:0] memQ[$], rdQ[$];
  int bad_count = 0, compares = 0;
  // Memory answers with a word derived from its address
  assign memRdData = memAddr ^ K;
  pit_bus_if bus ();
  pit_dev_end pit_dev_end_i (.*);
  pit_host_end pit_host_end_i (.*);
  pit_bus_properties pit_bus_properties_i (.clk_sys(clk_sys), .rst_b(rst_b), .frameB(bus.frameB),
    .irdyB(bus.irdyB), .trdyB(bus.trdyB), .devselB(bus.devselB), .cbeB(bus.cbeB), .ad(bus.ad),
    .dMstOeB(bus.dMstOeB), .dAdOeB(bus.dAdOeB), .dTgtOeB(bus.dTgtOeB));
  ////////////////////////////////////////////////////////////////////////////////
  initial forever #5 clk_sys = ~clk_sys;
  always @(negedge clk_sys)
  begin
    if (memWrStrobe) memQ.push_back({memBeB, memWrData ^ memAddr});
    if (rdValid && rdReady) rdQ.push_back({4'h0, rdData});
    if (tgtStrobe) {tSp, tData} = {2'b0, tgtSpace, tgtWrData};
  end
  task automatic chk(input logic [35:0] s, e);
    compares++;
    if (s !== e)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cpu(input logic w, c, input logic [31:0] a, d);
    {cpuValid, cpuWrite, cpuCfg, cpuAddr, cpuData, cpuStall} <= {1'b1, w, c, a, d, w};
    do @(posedge clk_sys); while (!cpuReady);
    cpuValid <= 1'b0;
    repeat (2) @(posedge clk_sys);
    cpuStall <= 1'b0;
    do @(posedge clk_sys); while (!cpuDone);
    r = cpuRdData;
  endtask
  // Stream push holds valid; the caller drops it
  task automatic push(input logic [31:0] d, input logic [3:0] b);
    {wrValid, wrData, wrBeB} <= {1'b1, d, b};
    do @(posedge clk_sys); while (!wrReady);
  endtask
  task automatic dma(input logic w, f, input logic [31:0] a);
    {dmaReqValid, dmaWrite, dmaFastB2b, dmaAddr} <= {1'b1, w, f, a};
    do @(posedge clk_sys); while (!dmaReqReady);
    dmaReqValid <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic idle;
    do @(posedge clk_sys); while (dmaBusy);
    repeat (4) @(posedge clk_sys);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 3; i++)
    begin
      tgtRdData <= 32'h1234_5670 + i;
      cpu(1'b1, i == 0, {14'h0, i != 0, i == 2, 16'h0010}, 32'hc0de_0000 + i);
      chk(tSp, i);
      chk(tData, 32'hc0de_0000 + i);
      cpu(1'b0, i == 0, {14'h0, i != 0, i == 2, 16'h0010}, 32'h0);
      chk(r, 32'h1234_5670 + i);
    end
    cpu(1'b0, 1'b0, 32'h0100_0000, 32'h0);
    chk(r, 32'hffff_ffff);
    $display("target spaces done");
    push(32'h5a5a_0001, 4'h0);
    push(32'h5a5a_0002, 4'hc);
    wrValid <= 1'b0;
    @(posedge clk_sys);
    chk(wrReady, 1'b0);
    dma(1'b1, 1'b0, 32'h0010_0000);
    idle();
    chk(memQ.size(), 2);
    chk(memQ[0], 36'h0_5a4a_0001);
    chk(memQ[1], 36'hc_5a4a_0006);
    $display("burst write done");
    rdReady <= 1'b0;
    dma(1'b0, 1'b0, 32'h0010_0100);
    idle();
    chk(rdValid, 1'b1);
    rdReady <= 1'b1;
    dma(1'b0, 1'b1, 32'h0010_0200);
    dma(1'b0, 1'b1, 32'h0010_0300);
    idle();
    chk(rdQ.size(), 6);
    for (int i = 0; i < 6; i++)
      chk(rdQ[i], (32'h0010_0100 + (i / 2) * 32'h100 + (i % 2) * 4) ^ K);
    $display("burst reads done");
    demuxMode <= 1'b1;
    cpu(1'b0, 1'b1, 32'h0000_0010, 32'h0);
    chk(r, 32'h1234_5672);
    chk(bus.par, 1'b0);
    $display("split mode done");
    results();
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    results();
  end
endmodule // tb_top
